// ==== core/config_control_cfg.svh ====
`ifndef CONFIG_CONTROL_CFG_SVH
`define CONFIG_CONTROL_CFG_SVH

`define CC_ADDR_W 4
`define CC_OFS_CONTROL 4'h0
`define CC_OFS_UNLOCK 4'h1
`define CC_OFS_PIN_SELECT 4'h2
`define CC_OFS_MODULE_DISABLE 4'h3
`define CC_OFS_STATUS 4'h4
`define CC_KEY_FIRST 32'hAA99_6655
`define CC_KEY_SECOND 32'h5566_99AA
`define CC_BIT_PIN_LOCK 13
`define CC_BIT_MOD_LOCK 12
`define CC_BIT_DEBUG_EN 3
`define CC_BIT_TDO_USE 0
`define CC_ONES_MASK 32'h0000_0006
`define CC_RESET_VALUE 32'h0000_000F
`define CC_PIN_SELECT_RESET 32'h0000_0000
`define CC_MODULE_DISABLE_RESET 32'h0000_0000
`define CC_BIT_STAT_PIN 0
`define CC_BIT_STAT_MOD 1
`define CC_BIT_STAT_LOCK 2
`define CC_RST_LOCK 1'b0
`define CC_RST_DEBUG_EN 1'b1
`define CC_RST_TDO_USE 1'b1
`define CC_RST_FLAG 1'b0
`define CC_READ_IDLE 32'h0000_0000

`endif

// ==== core/config_control_pkg.sv ====
package config_control_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef enum logic [1:0] {
    UNLOCK_IDLE,
    UNLOCK_HALF,
    UNLOCK_OPEN
  } unlock_state_t;
endpackage

// ==== core/unlock_sequencer.sv ====
`timescale 1ns/1ns
`include "config_control_cfg.svh"
module unlock_sequencer
  import config_control_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic key_write_in,
  input wire logic [31:0] key_data_in,
  input wire logic relock_in,
  output logic unlocked_out
);
  unlock_state_t state_reg;
  unlock_state_t state_next;

  // Any wrong key or unrelated relock closes the sequence again
  always_comb begin
    state_next = state_reg;
    if (relock_in) begin
      state_next = UNLOCK_IDLE;
    end else if (key_write_in) begin
      case (state_reg)
        UNLOCK_IDLE: state_next = (key_data_in == `CC_KEY_FIRST) ? UNLOCK_HALF : UNLOCK_IDLE;
        UNLOCK_HALF: state_next = (key_data_in == `CC_KEY_SECOND) ? UNLOCK_OPEN : UNLOCK_IDLE;
        UNLOCK_OPEN: state_next = UNLOCK_IDLE;
        default: state_next = UNLOCK_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg <= UNLOCK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign unlocked_out = (state_reg == UNLOCK_OPEN);
endmodule

// ==== core/config_control.sv ====
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "config_control_cfg.svh"
// Summary of operation
// - Pin-select lock bit 13 set refuses pin-select register writes; clear accepts them.
// - Module-disable lock bit 12 set refuses module-disable writes; clear accepts them.
// - Lock bits change only while the unlock sequence has opened the gate.
// - Bit 3 enables the debug port when one, disables when zero; read/write.
// - Bit 0 set makes two-wire debug use the test-out pin.
// - Bits 2 and 1 read as one; writes to them do nothing.
// - Bits 31-14 and 11-4 read zero; writes to them are ignored.
module config_control
  import config_control_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic debug_port_enable_out,
  output logic two_wire_test_out_use_out,
  output logic pin_select_lock_out,
  output logic module_disable_lock_out,
  output logic [31:0] pin_select_out,
  output logic [31:0] module_disable_out
);
  bus_req_t req;
  logic unlocked;
  logic key_write;
  logic ctrl_write;
  logic pin_lock_reg;
  logic mod_lock_reg;
  logic debug_en_reg;
  logic tdo_use_reg;
  logic [31:0] pin_select_reg;
  logic [31:0] module_disable_reg;
  logic [31:0] control_word;
  logic [31:0] rdata_next;
  logic pin_refused_reg;
  logic mod_refused_reg;
  logic lock_refused_reg;
  logic pin_write;
  logic mod_write;
  logic status_read;
  logic [31:0] status_word;

  // One decoder per index keeps each write path and its refusal flag in step
  function automatic logic write_hit(input bus_req_t r, input logic [3:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  function automatic logic read_hit(input bus_req_t r, input logic [3:0] ofs);
    return r.rd && (r.addr == ofs);
  endfunction

  assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
  assign key_write = write_hit(req, `CC_OFS_UNLOCK);
  assign ctrl_write = write_hit(req, `CC_OFS_CONTROL);
  assign pin_write = write_hit(req, `CC_OFS_PIN_SELECT);
  assign mod_write = write_hit(req, `CC_OFS_MODULE_DISABLE);
  assign status_read = read_hit(req, `CC_OFS_STATUS);

  // Gate closes after the first control write so each unlock permits one change
  unlock_sequencer unlock_inst (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .key_write_in(key_write),
    .key_data_in(req.wdata),
    .relock_in(ctrl_write),
    .unlocked_out(unlocked)
  );

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pin_lock_reg <= `CC_RST_LOCK;
    end else if (ctrl_write && unlocked) begin
      pin_lock_reg <= req.wdata[`CC_BIT_PIN_LOCK];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mod_lock_reg <= `CC_RST_LOCK;
    end else if (ctrl_write && unlocked) begin
      mod_lock_reg <= req.wdata[`CC_BIT_MOD_LOCK];
    end
  end

  // Debug bits need no unlock; only the two locks are guarded
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      debug_en_reg <= `CC_RST_DEBUG_EN;
    end else if (ctrl_write) begin
      debug_en_reg <= req.wdata[`CC_BIT_DEBUG_EN];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tdo_use_reg <= `CC_RST_TDO_USE;
    end else if (ctrl_write) begin
      tdo_use_reg <= req.wdata[`CC_BIT_TDO_USE];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pin_select_reg <= `CC_PIN_SELECT_RESET;
    end else if (pin_write && !pin_lock_reg) begin
      pin_select_reg <= req.wdata;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      module_disable_reg <= `CC_MODULE_DISABLE_RESET;
    end else if (mod_write && !mod_lock_reg) begin
      module_disable_reg <= req.wdata;
    end
  end

  // Sticky refusal flags; cleared by reading status, a new refusal wins
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pin_refused_reg <= `CC_RST_FLAG;
    end else if (pin_write && pin_lock_reg) begin
      pin_refused_reg <= 1'b1;
    end else if (status_read) begin
      pin_refused_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mod_refused_reg <= `CC_RST_FLAG;
    end else if (mod_write && mod_lock_reg) begin
      mod_refused_reg <= 1'b1;
    end else if (status_read) begin
      mod_refused_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      lock_refused_reg <= `CC_RST_FLAG;
    end else if (ctrl_write && !unlocked) begin
      lock_refused_reg <= 1'b1;
    end else if (status_read) begin
      lock_refused_reg <= 1'b0;
    end
  end

  always_comb begin
    control_word = `CC_ONES_MASK;
    control_word[`CC_BIT_PIN_LOCK] = pin_lock_reg;
    control_word[`CC_BIT_MOD_LOCK] = mod_lock_reg;
    control_word[`CC_BIT_DEBUG_EN] = debug_en_reg;
    control_word[`CC_BIT_TDO_USE] = tdo_use_reg;
  end

  // Status shows flags as they were before the clearing read takes effect
  always_comb begin
    status_word = `CC_READ_IDLE;
    status_word[`CC_BIT_STAT_PIN] = pin_refused_reg;
    status_word[`CC_BIT_STAT_MOD] = mod_refused_reg;
    status_word[`CC_BIT_STAT_LOCK] = lock_refused_reg;
  end

  // Zero outside the answer cycle so a shared read bus can simply OR slaves
  always_comb begin
    rdata_next = `CC_READ_IDLE;
    if (req.rd) begin
      case (req.addr)
        `CC_OFS_CONTROL: rdata_next = control_word;
        `CC_OFS_UNLOCK: rdata_next = {31'h0000_0000, unlocked};
        `CC_OFS_PIN_SELECT: rdata_next = pin_select_reg;
        `CC_OFS_MODULE_DISABLE: rdata_next = module_disable_reg;
        `CC_OFS_STATUS: rdata_next = status_word;
        default: rdata_next = `CC_READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdata_out <= `CC_READ_IDLE;
    end else begin
      rdata_out <= rdata_next;
    end
  end

  // Registered copies keep every output straight from a flip-flop
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      debug_port_enable_out <= `CC_RST_DEBUG_EN;
      two_wire_test_out_use_out <= `CC_RST_TDO_USE;
    end else begin
      debug_port_enable_out <= debug_en_reg;
      two_wire_test_out_use_out <= tdo_use_reg;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pin_select_lock_out <= `CC_RST_LOCK;
      module_disable_lock_out <= `CC_RST_LOCK;
    end else begin
      pin_select_lock_out <= pin_lock_reg;
      module_disable_lock_out <= mod_lock_reg;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pin_select_out <= `CC_PIN_SELECT_RESET;
      module_disable_out <= `CC_MODULE_DISABLE_RESET;
    end else begin
      pin_select_out <= pin_select_reg;
      module_disable_out <= module_disable_reg;
    end
  end
endmodule

// ==== testbench/config_control_monitor.sv ====
`timescale 1ns/1ns
module config_control_monitor (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic debug_port_enable_out,
  input wire logic two_wire_test_out_use_out,
  input wire logic pin_select_lock_out,
  input wire logic module_disable_lock_out,
  input wire logic [31:0] pin_select_out,
  input wire logic [31:0] module_disable_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // Lock outputs lag a cycle, so they judge a write one edge late
  chk_pin_refuse: assert property ((wr_in && addr_in == 4'h2) ##1 pin_select_lock_out
    |=> $stable(pin_select_out)) else $error("pin lock ignored");
  chk_pin_accept: assert property ((wr_in && addr_in == 4'h2) ##1 !pin_select_lock_out
    |=> pin_select_out == $past(wdata_in, 2)) else $error("pin write lost");
  chk_mod_refuse: assert property ((wr_in && addr_in == 4'h3) ##1 module_disable_lock_out
    |=> $stable(module_disable_out)) else $error("module lock ignored");
  chk_mod_accept: assert property ((wr_in && addr_in == 4'h3) ##1 !module_disable_lock_out
    |=> module_disable_out == $past(wdata_in, 2)) else $error("module write lost");
  chk_lock_hold: assert property (!(wr_in && addr_in == 4'h0) |-> ##2
    $stable(pin_select_lock_out) && $stable(module_disable_lock_out)) else $error("lock moved");
  chk_debug_follows: assert property (wr_in && addr_in == 4'h0 |-> ##2
    debug_port_enable_out == $past(wdata_in[3], 2)) else $error("debug enable wrong");
  chk_tdo_follows: assert property (wr_in && addr_in == 4'h0 |-> ##2
    two_wire_test_out_use_out == $past(wdata_in[0], 2)) else $error("test-out use wrong");
  chk_fixed_bits: assert property ($past(rd_in) && $past(addr_in) == 4'h0 |->
    rdata_out[2:1] == 2'b11 && rdata_out[31:14] == 18'h0 && rdata_out[11:4] == 8'h0)
    else $error("fixed bits wrong");
  chk_reset_state: assert property ($fell(reset_in) |-> debug_port_enable_out &&
    two_wire_test_out_use_out && !pin_select_lock_out && !module_disable_lock_out)
    else $error("reset state wrong");
  cover property ((wr_in && addr_in == 4'h2) ##1 pin_select_lock_out);
  cover property (pin_select_lock_out && module_disable_lock_out);
  cover property ($fell(pin_select_lock_out));
endmodule
bind config_control config_control_monitor mon_u (.*);

// ==== testbench/config_control_bench.sv ====
`timescale 1ns/1ns
module config_control_bench;
  logic core_clk_in = 0;
  logic reset_in = 1;
  logic wr_in = 0;
  logic rd_in = 0;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic [31:0] rdata_out, pin_select_out, module_disable_out;
  logic debug_port_enable_out, two_wire_test_out_use_out;
  logic pin_select_lock_out, module_disable_lock_out;
  logic [3:0] flags;
  int num_errors = 0;
  int n_checks = 0;
  assign flags = {pin_select_lock_out, module_disable_lock_out, debug_port_enable_out,
    two_wire_test_out_use_out};
  always #25 core_clk_in = ~core_clk_in;
  config_control dut_u (.*);
  task chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(logic [3:0] a, logic [31:0] exp);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 chk("rdata", rdata_out, exp);
  endtask
  task settle;
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask
  task unlock;
    wr(4'h1, 32'hAA99_6655);
    wr(4'h1, 32'h5566_99AA);
  endtask
  task t_reset;
    rd(4'h0, 32'h0000_000F);
    chk("flags", 32'(flags), 32'h0000_0003);
  endtask
  task t_closed;
    // Gate shut: lock bits in this word must be dropped
    wr(4'h0, 32'hFFFF_FFF6);
    rd(4'h0, 32'h0000_0006);
    settle;
    chk("flags", 32'(flags), 32'h0000_0000);
    wr(4'h0, 32'h0000_0009);
  endtask
  task t_open;
    wr(4'h2, 32'h1234_5678);
    wr(4'h3, 32'h0000_00C3);
    settle;
    chk("pin", pin_select_out, 32'h1234_5678);
    chk("mod", module_disable_out, 32'h0000_00C3);
  endtask
  task t_lock;
    unlock;
    rd(4'h1, 32'h0000_0001);
    wr(4'h0, 32'h0000_3009);
    wr(4'h2, 32'hA5A5_A5A5);
    wr(4'h3, 32'hFFFF_FFFF);
    wr(4'h0, 32'h0000_0008);
    rd(4'h0, 32'h0000_300E);
    settle;
    chk("pin", pin_select_out, 32'h1234_5678);
    chk("mod", module_disable_out, 32'h0000_00C3);
    rd(4'hF, 32'h0000_0000);
    rd(4'h4, 32'h0000_0007);
    rd(4'h4, 32'h0000_0000);
  endtask
  task t_bad_key;
    // A wrong second key must leave the gate shut and the locks set
    wr(4'h1, 32'hAA99_6655);
    wr(4'h1, 32'h0000_0000);
    wr(4'h1, 32'h5566_99AA);
    rd(4'h1, 32'h0000_0000);
    wr(4'h0, 32'h0000_0009);
    rd(4'h0, 32'h0000_300F);
  endtask
  task t_relock;
    unlock;
    wr(4'h0, 32'h0000_0009);
    wr(4'h2, 32'h0F0F_0F0F);
    settle;
    chk("flags", 32'(flags), 32'h0000_0003);
    chk("pin", pin_select_out, 32'h0F0F_0F0F);
  endtask
  task t_rerun;
    // Debug bits cleared first so the mid-run reset has something to restore
    wr(4'h0, 32'h0000_0000);
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    #1;
    chk("pin", pin_select_out, 32'h0000_0000);
    chk("mod", module_disable_out, 32'h0000_0000);
    chk("flags", 32'(flags), 32'h0000_0003);
    rd(4'h0, 32'h0000_000F);
    rd(4'h1, 32'h0000_0000);
  endtask
  task close_out;
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_reset;
    t_closed;
    t_open;
    t_lock;
    t_bad_key;
    t_relock;
    t_rerun;
    close_out;
  end
  initial begin
    #20000;
    num_errors++;
    close_out;
  end
endmodule
